// ===== src/csfr_pkg.sv
// package: constants for the processor status flag register
package csfr_pkg;
  // ==================================================
  // addresses (9-bit data space)
  localparam logic [8:0] CSFR_ADDR_LO = 9'h003;
  localparam logic [8:0] CSFR_ADDR_HI = 9'h083;
  localparam logic [6:0] CSFR_OFFSET  = 7'h03;
  // ==================================================
  // field positions
  localparam int CSFR_B_CARRY = 0;
  localparam int CSFR_B_NIB   = 1;
  localparam int CSFR_B_ZERO  = 2;
  localparam int CSFR_B_SLEEP = 3;
  localparam int CSFR_B_WDTO  = 4;
  localparam int CSFR_B_BSL   = 5;
  localparam int CSFR_B_BSH   = 6;
  localparam int CSFR_B_IBS   = 7;
  // ==================================================
  // reset value: banks 0, time-out and sleep flags set
  localparam logic [7:0] CSFR_RESET    = 8'h18;
  // bits that software may write directly
  localparam logic [7:0] CSFR_SW_MASK  = 8'hE7;
  // bits owned by the flag logic of arithmetic ops
  localparam logic [7:0] CSFR_ALU_MASK = 8'h07;
  // ==================================================
  // operation codes seen by the flag logic
  typedef enum logic [2:0] {
    CSFR_OP_NONE,
    CSFR_OP_ADD_REG,
    CSFR_OP_ADD_LIT,
    CSFR_OP_SUB_LIT,
    CSFR_OP_SUB_REG,
    CSFR_OP_LOGIC
  } csfr_op_t;
endpackage

// ===== src/csfr_status.sv
// processor status flag register with arithmetic flag logic
`timescale 1ns/100ps
module csfr_status
  import csfr_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_b,
  input  wire logic       i_clk_en,
  input  wire logic [8:0] i_addr,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_data,
  input  wire csfr_op_t   i_op,
  input  wire logic [7:0] i_opnd_a,
  input  wire logic [7:0] i_opnd_b,
  input  wire logic       i_zero_upd,
  input  wire logic       i_zero_val,
  input  wire logic       i_kick_instr,
  input  wire logic       i_halt_instr,
  input  wire logic       i_wdt_timeout,
  output logic      [7:0] o_rd_data,
  output logic      [7:0] o_status,
  output logic      [1:0] o_direct_bank,
  output logic            o_indirect_bank,
  output logic      [7:0] o_alu_result
);
  // ==================================================
  // decode
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] rd_data_ff;
  logic [1:0] dbank_ff;
  logic       ibank_ff;
  logic [7:0] result_ff;

  wire        hit     = (i_addr[6:0] == CSFR_OFFSET) && (i_addr[8] == 1'b0);
  wire        sw_wr   = i_wr_en && hit;
  wire        is_add  = (i_op == CSFR_OP_ADD_REG) || (i_op == CSFR_OP_ADD_LIT);
  wire        is_sub  = (i_op == CSFR_OP_SUB_REG) || (i_op == CSFR_OP_SUB_LIT);
  wire        arith   = is_add || is_sub;
  // subtract adds two's complement, so carry means no borrow
  wire [7:0]  opnd_b2 = is_sub ? ~i_opnd_b : i_opnd_b;
  wire        cin     = is_sub;
  // carry out of the low nibble
  wire [4:0]  nib_sum = {1'b0, i_opnd_a[3:0]} + {1'b0, opnd_b2[3:0]} + {4'h0, cin};
  wire [8:0]  full_sum = {1'b0, i_opnd_a} + {1'b0, opnd_b2} + {8'h00, cin};
  wire        zero_v  = arith ? (full_sum[7:0] == 8'h00) : i_zero_val;
  wire        zero_u  = arith || i_zero_upd;
  // own flag results mask software write of those bits
  wire [7:0]  wr_mask = CSFR_SW_MASK & ~(arith ? CSFR_ALU_MASK :
                        (zero_u ? 8'h04 : 8'h00));

  // ==================================================
  // next state
  always_comb begin
    nxt_status = status_ff;
    // hardware-only flags kept out of the write mask
    if (sw_wr) begin
      nxt_status = (status_ff & ~wr_mask) | (i_wr_data & wr_mask);
    end
    if (arith) begin
      nxt_status[CSFR_B_NIB]   = nib_sum[4];
      nxt_status[CSFR_B_CARRY] = full_sum[8];
    end
    if (zero_u) begin
      nxt_status[CSFR_B_ZERO] = zero_v;
    end
    // watchdog kick sets both reset-cause flags
    if (i_kick_instr) begin
      nxt_status[CSFR_B_SLEEP] = 1'b1;
      nxt_status[CSFR_B_WDTO]  = 1'b1;
    end
    // halt clears sleep flag, sets time-out flag
    if (i_halt_instr) begin
      nxt_status[CSFR_B_SLEEP] = 1'b0;
      nxt_status[CSFR_B_WDTO]  = 1'b1;
    end
    // watchdog event wins over the instructions
    if (i_wdt_timeout) begin
      nxt_status[CSFR_B_WDTO] = 1'b0;
    end
  end

  // ==================================================
  // registers
  // power-up value has sleep flag set
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_ff <= CSFR_RESET;
    end else if (i_clk_en) begin
      status_ff <= nxt_status;
    end
  end

  // bank selection loads the next-state bits, in step with the register
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dbank_ff   <= 2'h0;
      ibank_ff   <= 1'b0;
      rd_data_ff <= 8'h00;
      result_ff  <= 8'h00;
    end else if (i_clk_en) begin
      dbank_ff   <= nxt_status[CSFR_B_BSH:CSFR_B_BSL];
      ibank_ff   <= nxt_status[CSFR_B_IBS];
      rd_data_ff <= hit ? status_ff : 8'h00;
      result_ff  <= arith ? full_sum[7:0] : result_ff;
    end
  end

  assign o_status        = status_ff;
  assign o_rd_data       = rd_data_ff;
  assign o_direct_bank   = dbank_ff;
  assign o_indirect_bank = ibank_ff;
  assign o_alu_result    = result_ff;

  // ==================================================
  // checks
  // mirror read
  mirror_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && (i_addr == CSFR_ADDR_HI) |=> (o_rd_data == $past(status_ff)))
    else $error("mirror address read mismatch");

  base_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && (i_addr == CSFR_ADDR_LO) |=> (o_rd_data == $past(status_ff)))
    else $error("base address read mismatch");

  decode_miss_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && i_addr[8] |=> (o_rd_data == 8'h00))
    else $error("read data on a missed address");

  mirror_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && i_wr_en && (i_addr == CSFR_ADDR_HI)
      |=> (status_ff[CSFR_B_BSL] == $past(i_wr_data[CSFR_B_BSL])))
    else $error("write through mirror address lost");

  kick_sets_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && i_kick_instr && !i_halt_instr |=> status_ff[CSFR_B_SLEEP])
    else $error("kick did not set sleep flag");

  halt_clears_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && i_halt_instr |=> !status_ff[CSFR_B_SLEEP])
    else $error("halt did not clear sleep flag");

  nib_add_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && is_add |=> status_ff[CSFR_B_NIB] ==
      ($past(i_opnd_a[3:0]) + $past(i_opnd_b[3:0]) > 15))
    else $error("nibble overflow wrong on add");

  add_result_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && is_add |=> (o_alu_result == $past(i_opnd_a) + $past(i_opnd_b)))
    else $error("add result wrong");

  sub_borrow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && is_sub |=> status_ff[CSFR_B_NIB] ==
      ($past(i_opnd_a[3:0]) >= $past(i_opnd_b[3:0])))
    else $error("digit borrow polarity wrong");

  carry_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && is_sub |=> status_ff[CSFR_B_CARRY] ==
      ($past(i_opnd_a) >= $past(i_opnd_b)))
    else $error("carry borrow wrong on subtract");

  add_carry_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && is_add |=> status_ff[CSFR_B_CARRY] ==
      (({1'b0, $past(i_opnd_a)} + {1'b0, $past(i_opnd_b)}) > 9'h0FF))
    else $error("carry wrong on add");

  sub_result_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && is_sub |=> (o_alu_result == $past(i_opnd_a) - $past(i_opnd_b)))
    else $error("subtract result wrong");

  bank_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && sw_wr |=> (o_direct_bank == $past(i_wr_data[CSFR_B_BSH:CSFR_B_BSL])) &&
      (o_indirect_bank == $past(i_wr_data[CSFR_B_IBS])))
    else $error("bank select out of step");

  bank_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && !sw_wr |=> $stable(o_direct_bank) && $stable(o_indirect_bank))
    else $error("bank select moved without a write");

  alu_guard_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && sw_wr && arith |=> status_ff[CSFR_B_CARRY] == $past(full_sum[8]))
    else $error("software overwrote arithmetic flag");

  zero_guard_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && sw_wr && i_zero_upd && !arith
      |=> status_ff[CSFR_B_ZERO] == $past(i_zero_val))
    else $error("software overwrote zero flag");

  sub_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && sw_wr && is_sub |=> status_ff[CSFR_B_ZERO] ==
      ($past(i_opnd_a) == $past(i_opnd_b)))
    else $error("zero flag wrong on subtract");

  hw_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && !i_kick_instr && !i_halt_instr && !i_wdt_timeout
      |=> $stable(status_ff[4:3]))
    else $error("reset-cause flags changed by software");

  wdt_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_clk_en && i_wdt_timeout |=> !status_ff[CSFR_B_WDTO])
    else $error("time-out event did not clear flag");
endmodule

// ===== bench/csfr_status_bench.sv
// self-checking bench for the processor status flag register
`timescale 1ns/100ps
module csfr_status_bench;
  import csfr_pkg::*;
  // ==================================================
  // signals and model state
  logic        i_clk_sys, i_rst_b, i_clk_en, i_wr_en, i_zero_upd, i_zero_val;
  logic        i_kick_instr, i_halt_instr, i_wdt_timeout, o_indirect_bank;
  logic  [8:0] i_addr;
  logic  [7:0] i_wr_data, i_opnd_a, i_opnd_b, o_rd_data, o_status, o_alu_result, st, rd, alu;
  logic  [1:0] o_direct_bank;
  logic [15:0] rnd;
  csfr_op_t    i_op;
  int          miscompares, checks_done, cycles;
  csfr_status uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_op(i_op),
    .i_opnd_a(i_opnd_a), .i_opnd_b(i_opnd_b), .i_zero_upd(i_zero_upd),
    .i_zero_val(i_zero_val), .i_kick_instr(i_kick_instr), .i_halt_instr(i_halt_instr),
    .i_wdt_timeout(i_wdt_timeout), .o_rd_data(o_rd_data), .o_status(o_status),
    .o_direct_bank(o_direct_bank), .o_indirect_bank(o_indirect_bank),
    .o_alu_result(o_alu_result));
  // ==================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==================================================
  // stimulus: misses at 103h/183h test the decode
  task automatic drive();
    logic [2:0] op3;
    rnd = lfsr(rnd);
    op3 = (rnd[9:7] > 3'h5) ? rnd[9:7] - 3'h3 : rnd[9:7];
    i_clk_en <= rnd[3:0] != 4'h0;
    i_addr <= {rnd[5], rnd[4], 7'h03};
    i_wr_en <= rnd[6];
    i_op <= csfr_op_t'(op3);
    i_zero_upd <= op3 == 3'h5;
    i_zero_val <= rnd[13];
    i_kick_instr <= rnd[12:10] == 3'h1;
    i_halt_instr <= rnd[12:10] == 3'h2;
    i_wdt_timeout <= rnd[12:10] == 3'h3 || rnd[12:10] == 3'h4;
    rnd = lfsr(rnd);
    i_wr_data <= rnd[7:0] & 8'h3F;
    rnd = lfsr(rnd);
    {i_opnd_a, i_opnd_b} <= rnd;
  endtask
  // ==================================================
  // behavioural model, applied to the inputs of one edge
  task automatic model();
    int a, b, r;
    logic c, nib, ar, sb, hit;
    logic [7:0] m;
    if (!i_clk_en) return;
    ar = i_op inside {CSFR_OP_ADD_REG, CSFR_OP_ADD_LIT, CSFR_OP_SUB_LIT, CSFR_OP_SUB_REG};
    sb = i_op inside {CSFR_OP_SUB_LIT, CSFR_OP_SUB_REG};
    hit = i_addr == CSFR_ADDR_LO || i_addr == CSFR_ADDR_HI;
    rd = hit ? st : 8'h00;
    m = CSFR_SW_MASK & ~(ar ? CSFR_ALU_MASK : 8'h00) & ~(i_zero_upd ? 8'h04 : 8'h00);
    if (i_wr_en && hit) st = (st & ~m) | (i_wr_data & m);
    a = i_opnd_a;
    b = i_opnd_b;
    r = sb ? a - b : a + b;
    c = sb ? a >= b : r > 255;
    nib = sb ? a % 16 >= b % 16 : a % 16 + b % 16 > 15;
    r = r & 255;
    if (ar) {alu, st[2:0]} = {r[7:0], r == 0, nib, c};
    else if (i_zero_upd) st[2] = i_zero_val;
    if (i_kick_instr) st[4:3] = 2'b11;
    if (i_halt_instr) st[4:3] = 2'b10;
    if (i_wdt_timeout) st[4] = 1'b0;
  endtask
  task automatic check();
    cmp(o_status, st, "status");
    cmp(o_rd_data, rd, "read");
    cmp(o_alu_result, alu, "result");
    cmp({5'h00, o_indirect_bank, o_direct_bank}, {5'h00, st[7:5]}, "bank");
  endtask
  // ==================================================
  // clock, watchdog on the run, main sequence
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    {i_rst_b, i_clk_en, i_wr_en, i_zero_upd, i_zero_val, i_kick_instr} = 6'h00;
    {i_halt_instr, i_wdt_timeout, i_addr, i_wr_data, i_opnd_a, i_opnd_b} = 35'h0;
    i_op = CSFR_OP_NONE;
    {st, rd, alu, rnd} = {CSFR_RESET, 8'h00, 8'h00, 16'hF197};
    repeat (20) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    @(negedge i_clk_sys);
    check();
    $display("test reset done");
    // two random runs, each closed by a reset in mid-run
    repeat (2) begin
      repeat (1500) begin
        @(posedge i_clk_sys);
        drive();
        @(negedge i_clk_sys);
        check();
        model();
      end
      $display("test random done");
      @(posedge i_clk_sys);
      i_rst_b <= 1'b0;
      i_clk_en <= 1'b0;
      {st, rd, alu} = {CSFR_RESET, 8'h00, 8'h00};
      repeat (3) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(negedge i_clk_sys);
      check();
      $display("test mid-run reset done");
    end
    end_of_test();
  end
endmodule
